// File: src/apl_pkg.sv
// package for the automatic pause and jam logic
package apl_pkg;

	// ==========================================
	// register map
	localparam logic [7:0]  REG_FLOW_THRESHOLD_CONFIG = 8'hAC;
	localparam logic [7:0]  REG_FLOW_STATUS           = 8'hB4;
	localparam logic [31:0] CFG_RESET                 = 32'h0000_0000;
	localparam logic [31:0] CFG_WRITE_MASK            = 32'h00FF_FFFF;
	localparam logic [31:0] UNMAPPED_READ             = 32'h0000_0000;

	// ==========================================
	// field positions
	localparam int HI_LSB   = 16;
	localparam int LO_LSB   = 8;
	localparam int DUR_LSB  = 4;
	localparam int BIT_MULT = 3;
	localparam int BIT_BRD  = 2;
	localparam int BIT_OWN  = 1;
	localparam int BIT_ANY  = 0;
	localparam int UNIT_SHIFT = 6;   // levels count 64-byte units

	// ==========================================
	// timing: 50 MHz clock
	localparam int CLK_MHZ          = 50;
	localparam int DUR_EXTRA_10M_NS = 2200;
	localparam int EXTRA_10M_CYC    = (DUR_EXTRA_10M_NS * CLK_MHZ) / 1000;

	// jam duration in microseconds for codes 0h..Fh at 100 Mb/s
	function automatic int dur_us(input logic [3:0] code);
		case (code)
			4'h0: dur_us = 5;
			4'h1: dur_us = 10;
			4'h2: dur_us = 15;
			4'h3: dur_us = 25;
			4'h4: dur_us = 50;
			default: dur_us = 50 * (int'(code) - 3);
		endcase
	endfunction : dur_us

	// ==========================================
	// configuration carrier
	typedef struct packed {
		logic [7:0] high_level;
		logic [7:0] low_level;
		logic [3:0] jam_code;
		logic       jam_on_multicast;
		logic       jam_on_broadcast;
		logic       jam_on_own_address;
		logic       flow_on_any_frame;
	} apl_cfg_t;

	// receive-side frame event carrier
	typedef struct packed {
		logic preamble;
		logic multicast;
		logic broadcast;
		logic own_address;
	} apl_rx_evt_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_PAUSED = 3'b010,
		ST_JAM    = 3'b100
	} apl_state_t;

endpackage : apl_pkg

// File: src/apl_jam_timer.sv
// down counter that times one back-pressure interval
module apl_jam_timer #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// control
	input  wire logic             i_start,
	input  wire logic [CNT_W-1:0] i_cycles,
	// status
	output logic                  o_busy
);
	initial begin
		if (CNT_W < 16) $error("apl_jam_timer: counter too narrow");
	end

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;

	// ==========================================
	// count down; a new start reloads the interval
	always_comb begin
		cnt_next = cnt_reg;
		if (i_start) begin
			cnt_next = i_cycles;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign o_busy = (cnt_reg != '0);

endmodule : apl_jam_timer

// File: src/apl_auto_pause_logic.sv
// automatic pause frame and back-pressure control with its register
//
// Summary of operation
// - no pause or jam with transmitter off
// - high level bits 23:16 times 64
// - one pause frame per high crossing
// - half duplex jams matching frames for duration
// - below low level send zero pause
// - zero pause only after a pause
// - zero pause whenever any enable set
// - duration code bits 7:4, half duplex only
// - duration table, 10 Mb/s adds 2.2 us
// - bit 3 jams multicast frames
// - bit 2 jams broadcast frames
// - bit 1 jams own-address frames
// - any-frame bit overrides, jams on preamble
// - full duplex any-frame requests pause immediately
//
// register word at the config offset
//   31:24 read as zero, writes ignored
//   23:16 high level, in 64-byte units
//   15:8  low level, in 64-byte units
//   7:4   back-pressure duration code
//   3     jam multicast frames
//   2     jam broadcast frames
//   1     jam frames for our own address
//   0     flow control on any frame
//
// status word at the status offset, other bits read as zero
//   0     fill at or above the high level
//   1     pause sent, waiting for the low level
//   2     pause request pending at the mac
//   3     pending or last request carries zero time
//   4     back-pressure timer running
//
// bus timing: every access has one wait state. read data are
// registered in the first cycle; a write lands only at the edge
// where waitrequest is seen low, so an access that the master
// abandons early never touches the configuration.
//
// pause handshake: o_pause_req stands until the mac pulses
// i_pause_ack, or until the transmitter is switched off, which
// drops it. o_pause_zero tells the mac to send zero time instead
// of its own pause time value.
//
// back pressure: the timer counts system clocks, so the duration
// table holds only for the 50 MHz clock named in the package.
// a jam is not retriggered while the timer runs; a frame that
// arrives mid-jam is covered by the rest of the running interval.
//
// limitation: the low level must stay below the high level; with
// the two crossed the zero-time pause follows the first one at once.
//
// reset: synchronous and active high; the configuration reads zero,
// the pause machine idles and the jam timer is cleared.
//
// duplex: in full duplex only the any-frame bit arms the pause
// machine; bits 3:1 choose frames to jam only in half duplex.
module apl_auto_pause_logic #(
	parameter int FILL_W = 14,
	parameter int CNT_W  = 16
) (
	// clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	// avalon-mm slave
	input  wire logic [7:0]          i_address,
	input  wire logic                i_read,
	input  wire logic                i_write,
	input  wire logic [31:0]         i_writedata,
	input  wire logic [3:0]          i_byteenable,
	output logic      [31:0]         o_readdata,
	output logic                     o_waitrequest,
	// mac state
	input  wire logic                i_tx_enable,
	input  wire logic                i_full_duplex,
	input  wire logic                i_speed_100,
	input  wire logic [FILL_W-1:0]   i_rx_fill_bytes,
	input  wire apl_pkg::apl_rx_evt_t i_rx_evt,
	input  wire logic                i_pause_ack,
	// requests to the mac
	output logic                     o_pause_req,
	output logic                     o_pause_zero,
	output logic                     o_back_pressure
);
	initial begin
		if (FILL_W < 14) $error("apl_auto_pause_logic: fill count too narrow");
		if (CNT_W < 16) $error("apl_auto_pause_logic: jam counter too narrow");
	end

	// ==========================================
	// register bus
	logic [31:0]        cfg_reg;
	logic [31:0]        cfg_next;
	logic               ack_reg;
	logic               ack_next;
	logic [31:0]        rd_reg;
	logic [31:0]        rd_next;
	apl_pkg::apl_cfg_t  cfg;
	logic               any_en;

	assign cfg = apl_pkg::apl_cfg_t'(cfg_reg[23:0]);
	assign any_en = cfg.flow_on_any_frame | cfg.jam_on_multicast
		| cfg.jam_on_broadcast | cfg.jam_on_own_address;

	// ==========================================
	// flow state
	apl_pkg::apl_state_t state_reg;
	apl_pkg::apl_state_t state_next;
	logic                req_reg;
	logic                req_next;
	logic                zero_reg;
	logic                zero_next;
	logic                above_hi;
	logic                below_lo;
	logic                match;
	logic                jam_start;
	logic                jam_busy;
	logic [CNT_W-1:0]    jam_cycles;
	logic [31:0]         status_word;

	// status bit positions inside the status word
	localparam int STS_ABOVE_BIT  = 0;
	localparam int STS_PAUSED_BIT = 1;
	localparam int STS_REQ_BIT    = 2;
	localparam int STS_ZERO_BIT   = 3;
	localparam int STS_BUSY_BIT   = 4;

	// one-cycle answer: waitrequest drops in the cycle after the request
	always_comb begin
		cfg_next = cfg_reg;
		ack_next = 1'b0;
		rd_next  = rd_reg;
		if ((i_read | i_write) && !ack_reg) begin
			ack_next = 1'b1;
			if (i_read) begin
				case (i_address)
					apl_pkg::REG_FLOW_THRESHOLD_CONFIG: rd_next = cfg_reg;
					apl_pkg::REG_FLOW_STATUS: rd_next = status_word;
					default: rd_next = apl_pkg::UNMAPPED_READ;
				endcase
			end
		end
		// a write lands at the edge where waitrequest is seen low
		if (i_write && ack_reg && i_address == apl_pkg::REG_FLOW_THRESHOLD_CONFIG) begin
			for (int b = 0; b < 4; b++) begin
				if (i_byteenable[b]) begin
					cfg_next[b*8 +: 8] = i_writedata[b*8 +: 8];
				end
			end
			cfg_next = cfg_next & apl_pkg::CFG_WRITE_MASK;
		end
	end

	// status word; bits not listed read as zero
	always_comb begin
		status_word                 = '0;
		status_word[STS_ABOVE_BIT]  = above_hi;
		status_word[STS_PAUSED_BIT] = (state_reg == apl_pkg::ST_PAUSED);
		status_word[STS_REQ_BIT]    = req_reg;
		status_word[STS_ZERO_BIT]   = zero_reg;
		status_word[STS_BUSY_BIT]   = jam_busy;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cfg_reg <= apl_pkg::CFG_RESET;
			ack_reg <= 1'b0;
			rd_reg  <= '0;
		end else begin
			cfg_reg <= cfg_next;
			ack_reg <= ack_next;
			rd_reg  <= rd_next;
		end
	end

	assign o_waitrequest = (i_read | i_write) & ~ack_reg;
	assign o_readdata    = rd_reg;

	// ==========================================
	// level compare
	// fill in bytes against levels scaled to bytes
	// low level scaled
	// both sides widened to one width, so no scaled level can wrap
	localparam int LVL_W = 8 + apl_pkg::UNIT_SHIFT;
	localparam int CMP_W = (FILL_W > LVL_W) ? FILL_W : LVL_W;
	logic [CMP_W-1:0]    fill_cmp;
	logic [CMP_W-1:0]    hi_bytes;
	logic [CMP_W-1:0]    lo_bytes;

	assign fill_cmp = CMP_W'(i_rx_fill_bytes);
	assign hi_bytes = CMP_W'(cfg.high_level) << apl_pkg::UNIT_SHIFT;
	assign lo_bytes = CMP_W'(cfg.low_level) << apl_pkg::UNIT_SHIFT;
	assign above_hi = (fill_cmp >= hi_bytes);
	assign below_lo = (fill_cmp < lo_bytes);

	// ==========================================
	// frame match for half duplex
	// any overrides
	always_comb begin
		if (cfg.flow_on_any_frame) begin
			match = i_rx_evt.preamble;
		end else begin
			match = (cfg.jam_on_multicast & i_rx_evt.multicast)
				| (cfg.jam_on_broadcast & i_rx_evt.broadcast)
				| (cfg.jam_on_own_address & i_rx_evt.own_address);
		end
	end

	// longest interval is 30110 clocks, inside the 16-bit timer
	// duration table
	always_comb begin
		jam_cycles = CNT_W'(apl_pkg::dur_us(cfg.jam_code) * apl_pkg::CLK_MHZ);
		if (!i_speed_100) begin
			jam_cycles = jam_cycles + CNT_W'(apl_pkg::EXTRA_10M_CYC);
		end
	end

	// the start is refused while the timer runs: a retrigger would
	// stretch one jam without bound under a steady stream of frames
	// jam in half duplex
	assign jam_start = !i_full_duplex && i_tx_enable && above_hi && match && !jam_busy;

	apl_jam_timer #(
		.CNT_W (CNT_W)
	) u_jam_timer (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_start  (jam_start),
		.i_cycles (jam_cycles),
		.o_busy   (jam_busy)
	);

	assign o_back_pressure = jam_busy & i_tx_enable & ~i_full_duplex;

	// ==========================================
	// pause frame state machine, full duplex
	// one request at a time: neither branch raises a new request while
	// the mac still holds the previous one, so an ack never races a set.
	// a transmitter switched off drops the pending request outright.
	always_comb begin
		state_next = state_reg;
		req_next   = req_reg;
		zero_next  = zero_reg;
		if (req_reg && i_pause_ack) begin
			req_next = 1'b0;
		end
		case (state_reg)
			apl_pkg::ST_IDLE: begin
				if (i_full_duplex && i_tx_enable && cfg.flow_on_any_frame && above_hi
						&& !req_reg) begin
					state_next = apl_pkg::ST_PAUSED;
					req_next   = 1'b1;
					zero_next  = 1'b0;
				end
			end
			apl_pkg::ST_PAUSED: begin
				if (below_lo && any_en && i_tx_enable && !req_reg) begin
					state_next = apl_pkg::ST_IDLE;
					req_next   = 1'b1;
					zero_next  = 1'b1;
				end
			end
			default: state_next = apl_pkg::ST_IDLE;
		endcase
		if (!i_tx_enable) begin
			req_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= apl_pkg::ST_IDLE;
			req_reg   <= 1'b0;
			zero_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_reg   <= req_next;
			zero_reg  <= zero_next;
		end
	end

	// pause time comes from the mac unless zero flagged
	assign o_pause_req  = req_reg;
	assign o_pause_zero = zero_reg;

endmodule : apl_auto_pause_logic

// File: tb/apl_auto_pause_sva.sv
// port checker for the automatic pause and jam logic
module apl_auto_pause_sva #(
	parameter int FILL_W = 14
) (
	// clock, reset and bus
	input wire logic	i_clk,
	input wire logic	i_rst,
	input wire logic [7:0]	i_address,
	input wire logic	i_read,
	input wire logic	i_write,
	input wire logic [31:0]	i_writedata,
	input wire logic	o_waitrequest,
	// mac side
	input wire logic	i_tx_enable,
	input wire logic	i_full_duplex,
	input wire logic [FILL_W-1:0]	i_rx_fill_bytes,
	input wire apl_pkg::apl_rx_evt_t	i_rx_evt,
	input wire logic	i_pause_ack,
	input wire logic	o_pause_req,
	input wire logic	o_pause_zero,
	input wire logic	o_back_pressure
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0]	cfg_reg;
	// shadow of the config word; bench writes whole words only
	always_ff @(posedge i_clk) begin
		if (i_rst)
			cfg_reg <= 32'h0000_0000;
		else if (i_write && !o_waitrequest && i_address == 8'hAC)
			cfg_reg <= i_writedata;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ========
	// port relations
	one_wait_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("bus access not answered");
	tx_off_jam_a: assert property (!i_tx_enable |-> !o_back_pressure)
		else $error("jam with transmitter off");
	pause_tx_a: assert property ($rose(o_pause_req) |-> $past(i_tx_enable))
		else $error("pause with transmitter off");
	duplex_jam_a: assert property (i_full_duplex |-> !o_back_pressure)
		else $error("jam in full duplex");
	high_pause_a: assert property ($rose(o_pause_req) && !o_pause_zero |->
		$past(i_full_duplex) && $past(i_rx_fill_bytes) >= {cfg_reg[23:16], 6'h00})
		else $error("pause below high level");
	zero_pause_a: assert property ($rose(o_pause_req) && o_pause_zero |->
		$past(i_rx_fill_bytes) < {cfg_reg[15:8], 6'h00} && cfg_reg[3:0] != 4'h0)
		else $error("zero pause above low level");
	req_hold_a: assert property (o_pause_req && !i_pause_ack && i_tx_enable |=>
		o_pause_req && $stable(o_pause_zero))
		else $error("pause request dropped early");
	jam_cause_a: assert property ($rose(o_back_pressure) |->
		$past(i_rx_evt) != 4'h0 && $past(i_rx_fill_bytes) >= {cfg_reg[23:16], 6'h00})
		else $error("jam without frame");
endmodule : apl_auto_pause_sva

bind apl_auto_pause_logic apl_auto_pause_sva #(.FILL_W(FILL_W)) i_sva (
	.i_clk, .i_rst, .i_address, .i_read, .i_write, .i_writedata, .o_waitrequest,
	.i_tx_enable, .i_full_duplex, .i_rx_fill_bytes, .i_rx_evt, .i_pause_ack,
	.o_pause_req, .o_pause_zero, .o_back_pressure
);

// File: tb/apl_mac_model.sv
// far-side model: the mac takes a pause request after a transmit window
module apl_mac_model #(
	parameter int ACK_GAP = 3
) (
	// clock and reset
	input wire logic	i_clk,
	input wire logic	i_rst,
	// pause handshake
	input wire logic	i_req,
	output logic	o_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	int	wait_cnt;
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_req || o_ack) begin
			wait_cnt <= 0;
			o_ack <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 1;
			o_ack <= (wait_cnt == ACK_GAP);
		end
	end
endmodule : apl_mac_model

// File: tb/apl_auto_pause_logic_test.sv
// self-checking bench for the automatic pause and jam logic
module apl_auto_pause_logic_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic	clk, ack, wreq, preq, pzero, bp;
	logic	rst = 1'b1, rd = 1'b0, wr = 1'b0, tx = 1'b0, fd = 1'b1, s100 = 1'b1;
	logic [7:0]	adr = 8'h00;
	logic [31:0]	wdat = 32'h0, rdat, got;
	logic [13:0]	fill = 14'h0;
	apl_pkg::apl_rx_evt_t	evt = 4'h0;
	int	err_total = 0, comparisons = 0;

	apl_auto_pause_logic i_dut (
		.i_clk(clk), .i_rst(rst), .i_address(adr), .i_read(rd), .i_write(wr),
		.i_writedata(wdat), .i_byteenable(4'hF), .o_readdata(rdat), .o_waitrequest(wreq),
		.i_tx_enable(tx), .i_full_duplex(fd), .i_speed_100(s100), .i_rx_fill_bytes(fill),
		.i_rx_evt(evt), .i_pause_ack(ack), .o_pause_req(preq), .o_pause_zero(pzero),
		.o_back_pressure(bp));
	apl_mac_model i_mac (.i_clk(clk), .i_rst(rst), .i_req(preq), .o_ack(ack));

	task automatic tally_and_finish;
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// one avalon access, held until waitrequest is sampled low at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		// values read here are those standing at this edge
		got = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (wreq !== 1'b0) begin
			err_total++;
			tally_and_finish();
		end
	endtask : bus

	// neither pause nor jam may show for n cycles
	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge clk);
			seen = seen | preq | bp;
		end
		chk({31'h0, seen}, 32'h0);
	endtask : quiet

	task automatic expect_req(input logic z);
		int n;
		for (n = 0; n < 20 && preq !== 1'b1; n++)
			@(negedge clk);
		chk({30'h0, preq, pzero}, {30'h0, 1'b1, z});
		for (n = 0; n < 20 && preq !== 1'b0; n++)
			@(negedge clk);
		chk({31'h0, preq}, 32'h0);
	endtask : expect_req

	// pulse one frame event and count the jam cycles that follow
	task automatic jam_len(input logic [3:0] v, input int e);
		int n;
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= 4'h0;
		n = 0;
		repeat (e + 20) begin
			@(negedge clk);
			n += int'(bp === 1'b1);
		end
		chk(32'(n), 32'(e));
	endtask : jam_len

	task automatic reg_scn;
		bus(0, 8'hAC, 0);
		chk(got, 32'h0000_0000);
		bus(1, 8'hAC, 32'hFFFF_FFFF);
		bus(0, 8'hAC, 0);
		chk(got, 32'h00FF_FFFF);
		bus(0, 8'h00, 0);
		chk(got, 32'h0000_0000);
	endtask : reg_scn

	task automatic pause_scn;
		bus(1, 8'hAC, 32'h0002_0101);
		fill <= 14'd128;
		quiet(20);
		@(posedge clk);
		tx <= 1'b1;
		fill <= 14'd63;
		quiet(20);
		@(posedge clk);
		fill <= 14'd127;
		quiet(20);
		@(posedge clk);
		fill <= 14'd128;
		expect_req(1'b0);
		quiet(40);
		bus(0, 8'hB4, 0);
		chk(got, 32'h0000_0003);
		@(posedge clk);
		fill <= 14'd64;
		quiet(20);
		@(posedge clk);
		fill <= 14'd63;
		expect_req(1'b1);
	endtask : pause_scn

	// each frame-type bit with its own event, at the shortest duration
	task automatic jam_scn;
		@(posedge clk);
		fd <= 1'b0;
		fill <= 14'd200;
		for (int b = 0; b < 4; b++) begin
			bus(1, 8'hAC, 32'h0002_0100 | (32'h1 << b));
			jam_len(b == 0 ? 4'h8 : 4'h1 << (b - 1), 250);
		end
		jam_len(4'h2, 0);
		bus(1, 8'hAC, 32'h0002_0158);
		s100 <= 1'b0;
		jam_len(4'h4, 5110);
		@(posedge clk);
		fill <= 14'd127;
		jam_len(4'h4, 0);
		@(posedge clk);
		fill <= 14'd200;
		tx <= 1'b0;
		jam_len(4'h4, 0);
		@(posedge clk);
		tx <= 1'b1;
		fd <= 1'b1;
		jam_len(4'h4, 0);
	endtask : jam_scn

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		reg_scn();
		pause_scn();
		jam_scn();
		tally_and_finish();
	end
endmodule : apl_auto_pause_logic_test
